//--- pkg/plq_pkg.sv
// Purpose: Constants and carrier types for the link quality, test and scrambler register group.
// Assumes: 16-bit registers reached over a plain address/strobe port, one clock, active-low reset.
// Notes on behaviour
// (R1) Pattern order bit 8 swaps pair order.
// (R2) Constant-data mode sends byte bits 7-0.
// (R3) Training time in ms, read-only, bits 7-0.
// (R4) Remote lock 15-8, local lock 7-0.
// (R5) Bit 5 clears while channel-good is low and sets when it rises; write-zero clears.
// (R6) Bit 4 latches fail-inhibit high; write-zero clears.
// (R7) Bit 3 latches startup detect high; write-zero clears.
// (R8) Bit 2 latches frame error rate high.
// (R9) Bit 1 latches alignment loss; write-zero sets.
// (R10) Bit 0 latches watchdog low; write-zero sets.
// (R11) Six-bit link loss counter at 15-10.
// (R12) Ten-bit fail-without-loss counter at 9-0.
// (R13) Communication ready status at bit 0.
// (R14) Force enable bit 5 applies force value bit 6.
// (R15) Standard watchdog bit 4 starts counters after link.
// (R16) Symbol counts below threshold drive watchdog status low.
// (R17) Corrupt enable XORs error value onto memory data.
// (R18) Bit 4 delays receive descrambler one bit.
// (R19) Bit 3 delays transmit scrambler one bit.
// (R20) Receive symbols from S14 or S0 by bit 2.
// (R21) Transmit symbols from S14 or S0 by bit 1.
// (R22) Bit 0 bypasses scrambler both directions.
// (R23) Counters saturate, clear only on reset.
`default_nettype none
package plq_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_TEST = 12'h531;
   localparam logic [11:0] OFF_TRAIN = 12'h543;
   localparam logic [11:0] OFF_LOCK = 12'h544;
   localparam logic [11:0] OFF_LATCH = 12'h545;
   localparam logic [11:0] OFF_DROP = 12'h547;
   localparam logic [11:0] OFF_READY = 12'h548;
   localparam logic [11:0] OFF_WDOG = 12'h559;
   localparam logic [11:0] OFF_SCR = 12'h55a;
   localparam int TEST_SWAP_BIT = 8;
   localparam logic [15:0] TEST_MASK = 16'h01ff;
   localparam logic [15:0] WDOG_RESET = 16'h0051;
   localparam logic [15:0] WDOG_MASK = 16'h007f;
   localparam logic [15:0] SCR_RESET = 16'h0000;
   localparam logic [15:0] SCR_MASK = 16'h7fff;
   localparam int WD_FVAL_BIT = 6;
   localparam int WD_FEN_BIT = 5;
   localparam int WD_STD_BIT = 4;
   localparam int SCR_ERR_LSB = 6;
   localparam int SCR_CORRUPT_BIT = 5;
   localparam int SCR_RXDLY_BIT = 4;
   localparam int SCR_TXDLY_BIT = 3;
   localparam int SCR_RXORD_BIT = 2;
   localparam int SCR_TXORD_BIT = 1;
   localparam int SCR_BYPASS_BIT = 0;
   localparam int LAT_CHAN = 5;
   localparam int LAT_FAIL = 4;
   localparam int LAT_START = 3;
   localparam int LAT_FER = 2;
   localparam int LAT_ALIGN = 1;
   localparam int LAT_WDOG = 0;
   localparam int LOSS_W = 6;
   localparam int FAIL_W = 10;
   localparam int WIN_CYCLES = 256;
   localparam int SCR_LEN = 15;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } plq_req_s;
   typedef struct packed {
      logic channel_good;
      logic fail_inhibit;
      logic startup_detect;
      logic frame_error_high;
      logic alignment_lock;
      logic link_up;
      logic link_loss;
      logic link_fail;
      logic comm_ready;
   } plq_evt_s;
   typedef struct packed {
      logic sym_zero;
      logic sym_plus;
      logic sym_minus;
   } plq_sym_s;
endpackage
`default_nettype wire

//--- verilog/plq_regs.sv
// Purpose: Link quality report, latched link-down status, symbol watchdog and scrambler option logic.
// Assumes: Event inputs come from outside this clock and are synchronised here; data paths are same-clock.
// Notes: Timer values are supplied by the training logic outside and only captured for reading here.
`default_nettype none
module plq_regs #(
   parameter int WIN_CYCLES = plq_pkg::WIN_CYCLES
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire plq_pkg::plq_req_s req_in,
   output logic [15:0] rdata_out,
   input wire plq_pkg::plq_evt_s evt_in,
   input wire logic [7:0] train_ms_in,
   input wire logic [7:0] remote_lock_ms_in,
   input wire logic [7:0] local_lock_ms_in,
   input wire plq_pkg::plq_sym_s sym_in,
   input wire logic pattern_a_in,
   input wire logic pattern_b_in,
   input wire logic constant_mode_in,
   output logic [7:0] tx_data_out,
   output logic first_pattern_out,
   output logic second_pattern_out,
   output logic watchdog_status_out,
   input wire logic [8:0] mem_data_in,
   output logic [8:0] mem_data_out,
   input wire logic tx_data_bit_in,
   input wire logic rx_data_bit_in,
   output logic tx_scr_bit_out,
   output logic rx_descr_bit_out
);
   localparam int EVW = $bits(plq_pkg::plq_evt_s);

   logic [15:0] test_reg;
   logic [15:0] wdog_reg;
   logic [15:0] scr_reg;
   logic [5:0] latch;
   logic [7:0] train_ms;
   logic [15:0] lock_ms;
   logic [plq_pkg::LOSS_W-1:0] loss_cnt;
   logic [plq_pkg::FAIL_W-1:0] fail_cnt;
   logic [EVW-1:0] sync1, sync2, sync3;
   logic [EVW-1:0] evt_stable;
   logic [EVW-1:0] evt_prev;
   logic [3:0] cnt_zero, cnt_plus, cnt_minus;
   logic [15:0] win_cnt;
   logic wd_raw;
   logic [plq_pkg::SCR_LEN-1:0] tx_lfsr, rx_lfsr;
   logic tx_sym_d, rx_sym_d;

   // Event inputs pass three flops; a level change is accepted only when the last two agree.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= evt_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   wire [EVW-1:0] agree = ~(sync2 ^ sync3);
   wire [EVW-1:0] next_stable = (agree & sync3) | (~agree & evt_stable);
   plq_pkg::plq_evt_s ev, ev_prev;
   assign ev = evt_stable;
   assign ev_prev = evt_prev;
   wire rise_loss = ev.link_loss & ~ev_prev.link_loss;
   wire rise_fail = ev.link_fail & ~ev_prev.link_fail;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         evt_stable <= '0;
         evt_prev <= '0;
      end else begin
         evt_stable <= next_stable;
         evt_prev <= evt_stable;
      end
   end

   // Register decode.
   wire hit_test = req_in.addr == plq_pkg::OFF_TEST;
   wire hit_latch = req_in.addr == plq_pkg::OFF_LATCH;
   wire hit_wdog = req_in.addr == plq_pkg::OFF_WDOG;
   wire hit_scr = req_in.addr == plq_pkg::OFF_SCR;
   wire wr_latch = req_in.wr & hit_latch;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         test_reg <= '0;
         wdog_reg <= plq_pkg::WDOG_RESET;
         scr_reg <= plq_pkg::SCR_RESET;
      end else begin
         if (req_in.wr && hit_test)
            test_reg <= req_in.wdata & plq_pkg::TEST_MASK;
         if (req_in.wr && hit_wdog)
            wdog_reg <= req_in.wdata & plq_pkg::WDOG_MASK;
         if (req_in.wr && hit_scr)
            scr_reg <= req_in.wdata & plq_pkg::SCR_MASK;
      end
   end

   // Latch bits: hardware set or clear wins over a software write in the same cycle.
   wire [5:0] wz = wr_latch ? ~req_in.wdata[5:0] : 6'h00;
   logic [5:0] next_latch;
   always_comb begin
      next_latch = latch;
      // A latch-low bit reads 1 only while the condition has held since the bit was set; channel-good sets on its rise.
      if (wz[plq_pkg::LAT_CHAN])
         next_latch[plq_pkg::LAT_CHAN] = 1'b0; // R5
      if (!ev.channel_good)
         next_latch[plq_pkg::LAT_CHAN] = 1'b0; // R5
      else if (!ev_prev.channel_good)
         next_latch[plq_pkg::LAT_CHAN] = 1'b1; // R5
      if (wz[plq_pkg::LAT_FAIL])
         next_latch[plq_pkg::LAT_FAIL] = 1'b0; // R6
      if (ev.fail_inhibit)
         next_latch[plq_pkg::LAT_FAIL] = 1'b1; // R6
      if (wz[plq_pkg::LAT_START])
         next_latch[plq_pkg::LAT_START] = 1'b0; // R7
      if (ev.startup_detect)
         next_latch[plq_pkg::LAT_START] = 1'b1; // R7
      if (wz[plq_pkg::LAT_FER])
         next_latch[plq_pkg::LAT_FER] = 1'b0; // R8
      if (ev.frame_error_high)
         next_latch[plq_pkg::LAT_FER] = 1'b1; // R8
      if (wz[plq_pkg::LAT_ALIGN])
         next_latch[plq_pkg::LAT_ALIGN] = 1'b1; // R9
      if (!ev.alignment_lock)
         next_latch[plq_pkg::LAT_ALIGN] = 1'b0; // R9
      if (wz[plq_pkg::LAT_WDOG])
         next_latch[plq_pkg::LAT_WDOG] = 1'b1; // R10
      if (!watchdog_status_out)
         next_latch[plq_pkg::LAT_WDOG] = 1'b0; // R10
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         latch <= '0;
      end else begin
         latch <= next_latch;
      end
   end

   // Report registers and saturating counters.
   wire [plq_pkg::LOSS_W-1:0] next_loss = (rise_loss && !(&loss_cnt)) ? loss_cnt + 1'b1 : loss_cnt;
   wire [plq_pkg::FAIL_W-1:0] next_fail = (rise_fail && !ev.link_loss && !(&fail_cnt)) ? fail_cnt + 1'b1 : fail_cnt;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         train_ms <= '0;
         lock_ms <= '0;
         loss_cnt <= '0;
         fail_cnt <= '0;
      end else begin
         train_ms <= train_ms_in; // R3
         lock_ms <= {remote_lock_ms_in, local_lock_ms_in}; // R4
         loss_cnt <= next_loss; // R11 R23
         fail_cnt <= next_fail; // R12 R23
      end
   end

   // Read mux; unmapped addresses read zero.
   logic [15:0] rd_mux;
   always_comb begin
      unique case (req_in.addr)
         plq_pkg::OFF_TEST: rd_mux = test_reg;
         plq_pkg::OFF_TRAIN: rd_mux = {8'h00, train_ms}; // R3
         plq_pkg::OFF_LOCK: rd_mux = lock_ms; // R4
         plq_pkg::OFF_LATCH: rd_mux = {10'h000, latch};
         plq_pkg::OFF_DROP: rd_mux = {loss_cnt, fail_cnt}; // R11 R12
         plq_pkg::OFF_READY: rd_mux = {15'h0000, ev.comm_ready}; // R13
         plq_pkg::OFF_WDOG: rd_mux = wdog_reg;
         plq_pkg::OFF_SCR: rd_mux = scr_reg;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= req_in.rd ? rd_mux : 16'h0000;
      end
   end

   // Test pattern outputs.
   wire swap = test_reg[plq_pkg::TEST_SWAP_BIT];
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_data_out <= '0;
         first_pattern_out <= 1'b0;
         second_pattern_out <= 1'b0;
      end else begin
         tx_data_out <= constant_mode_in ? test_reg[7:0] : 8'h00; // R2
         first_pattern_out <= swap ? pattern_b_in : pattern_a_in; // R1
         second_pattern_out <= swap ? pattern_a_in : pattern_b_in; // R1
      end
   end

   // Symbol watchdog: each symbol kind needs the threshold count inside a window.
   wire std_en = wdog_reg[plq_pkg::WD_STD_BIT];
   wire [3:0] thresh = wdog_reg[3:0];
   wire wd_run = !std_en || ev.link_up; // R15
   wire win_end = win_cnt == 16'(WIN_CYCLES - 1);
   // Counts include this cycle's symbol so that a symbol in the last cycle of a window is not lost.
   wire [3:0] seen_zero = cnt_zero + {3'h0, sym_in.sym_zero && cnt_zero != 4'hf};
   wire [3:0] seen_plus = cnt_plus + {3'h0, sym_in.sym_plus && cnt_plus != 4'hf};
   wire [3:0] seen_minus = cnt_minus + {3'h0, sym_in.sym_minus && cnt_minus != 4'hf};
   wire short_any = (seen_zero < thresh) || (seen_plus < thresh) || (seen_minus < thresh); // R16

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         win_cnt <= '0;
         cnt_zero <= '0;
         cnt_plus <= '0;
         cnt_minus <= '0;
         wd_raw <= 1'b0;
      end else if (!wd_run) begin
         win_cnt <= '0;
         cnt_zero <= '0;
         cnt_plus <= '0;
         cnt_minus <= '0;
         wd_raw <= 1'b0;
      end else if (win_end) begin
         win_cnt <= '0;
         cnt_zero <= '0;
         cnt_plus <= '0;
         cnt_minus <= '0;
         wd_raw <= short_any; // R16
      end else begin
         win_cnt <= win_cnt + 16'h0001;
         cnt_zero <= seen_zero;
         cnt_plus <= seen_plus;
         cnt_minus <= seen_minus;
      end
   end

   // The status output is active high; the latch bit tracks its low level.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         watchdog_status_out <= 1'b1;
      end else begin
         watchdog_status_out <= wdog_reg[plq_pkg::WD_FEN_BIT] ? wdog_reg[plq_pkg::WD_FVAL_BIT] : !wd_raw; // R14
      end
   end

   // Memory data corruption for exercising the error-correcting path.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_data_out <= '0;
      end else begin
         mem_data_out <= mem_data_in ^ (scr_reg[plq_pkg::SCR_CORRUPT_BIT] ?
            scr_reg[plq_pkg::SCR_ERR_LSB +: 9] : 9'h000); // R17
      end
   end

   // Additive free-running scrambler state, x^15 + x^14 + 1 feedback.
   wire tx_fb = tx_lfsr[14] ^ tx_lfsr[13];
   wire rx_fb = rx_lfsr[14] ^ rx_lfsr[13];
   wire tx_sym = scr_reg[plq_pkg::SCR_TXORD_BIT] ? tx_lfsr[0] : tx_lfsr[14]; // R21
   wire rx_sym = scr_reg[plq_pkg::SCR_RXORD_BIT] ? rx_lfsr[0] : rx_lfsr[14]; // R20
   wire tx_use = scr_reg[plq_pkg::SCR_TXDLY_BIT] ? tx_sym_d : tx_sym; // R19
   wire rx_use = scr_reg[plq_pkg::SCR_RXDLY_BIT] ? rx_sym_d : rx_sym; // R18
   wire bypass = scr_reg[plq_pkg::SCR_BYPASS_BIT];

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_lfsr <= 15'h7fff;
         rx_lfsr <= 15'h7fff;
         tx_sym_d <= 1'b0;
         rx_sym_d <= 1'b0;
         tx_scr_bit_out <= 1'b0;
         rx_descr_bit_out <= 1'b0;
      end else begin
         tx_lfsr <= {tx_lfsr[13:0], tx_fb};
         rx_lfsr <= {rx_lfsr[13:0], rx_fb};
         tx_sym_d <= tx_sym;
         rx_sym_d <= rx_sym;
         tx_scr_bit_out <= bypass ? tx_data_bit_in : tx_data_bit_in ^ tx_use; // R22
         rx_descr_bit_out <= bypass ? rx_data_bit_in : rx_data_bit_in ^ rx_use; // R22
      end
   end
endmodule
`default_nettype wire

//--- verif/plq_regs_props.sv
// Purpose: Port-level checks for the link quality, test and scrambler register group.
// Assumes: One clock, asynchronous active-low reset, read data one cycle after the read strobe.
// Notes: Only relations visible at the top module's ports are checked here.
`default_nettype none
module plq_regs_props #(
   parameter int WIN_CYCLES = 256
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire plq_pkg::plq_req_s req_in,
   input wire logic [15:0] rdata_out,
   input wire logic [7:0] train_ms_in,
   input wire logic [7:0] remote_lock_ms_in,
   input wire logic [7:0] local_lock_ms_in,
   input wire logic constant_mode_in,
   input wire logic [7:0] tx_data_out,
   input wire logic pattern_a_in,
   input wire logic pattern_b_in,
   input wire logic first_pattern_out,
   input wire logic second_pattern_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   wire logic [11:0] ra = req_in.addr;
   wire logic [15:0] lock_word = {remote_lock_ms_in, local_lock_ms_in};
   sequence rd_at(logic [11:0] x);
      req_in.rd && ra == x;
   endsequence
   // A write followed at once by a read of the same place must show the masked write data.
   sequence wr_rd(logic [11:0] x);
      req_in.wr && ra == x ##1 rd_at(x);
   endsequence
   test_readback_a: assert property (wr_rd(plq_pkg::OFF_TEST) |=>
      rdata_out == ($past(req_in.wdata, 2) & 16'h01ff)) else $error("test register readback wrong");
   wdog_readback_a: assert property (wr_rd(plq_pkg::OFF_WDOG) |=>
      rdata_out == ($past(req_in.wdata, 2) & 16'h007f)) else $error("watchdog config readback wrong");
   scr_readback_a: assert property (wr_rd(plq_pkg::OFF_SCR) |=>
      rdata_out == ($past(req_in.wdata, 2) & 16'h7fff)) else $error("scrambler config readback wrong");
   train_read_a: assert property (rd_at(plq_pkg::OFF_TRAIN) and $stable(train_ms_in) |=>
      rdata_out == {8'h00, $past(train_ms_in)}) else $error("training time read wrong");
   lock_read_a: assert property (rd_at(plq_pkg::OFF_LOCK) and $stable(lock_word) |=>
      rdata_out == $past(lock_word)) else $error("lock time read wrong");
   latch_field_a: assert property (rd_at(plq_pkg::OFF_LATCH) |=>
      rdata_out[15:6] == 10'h000) else $error("latch word reserved bits set");
   const_idle_a: assert property (!constant_mode_in |=>
      tx_data_out == 8'h00) else $error("test byte sent outside constant mode");
   pattern_same_a: assert property (pattern_a_in == pattern_b_in |=>
      first_pattern_out == $past(pattern_a_in) && second_pattern_out == $past(pattern_a_in))
      else $error("pattern outputs do not follow equal inputs");
endmodule
bind plq_regs plq_regs_props #(.WIN_CYCLES(WIN_CYCLES)) u_props (.clk_in, .resetn_in, .req_in, .rdata_out,
   .train_ms_in, .remote_lock_ms_in, .local_lock_ms_in, .constant_mode_in, .tx_data_out, .pattern_a_in,
   .pattern_b_in, .first_pattern_out, .second_pattern_out);
`default_nettype wire

//--- verif/tb_plq_regs.sv
// Purpose: Self-checking bench for the link quality, test and scrambler register group.
// Assumes: Event inputs settle within eight cycles through the synchronisers.
// Notes: The watchdog window is cut to 16 cycles so the symbol checks stay short.
`default_nettype none
module tb_plq_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   plq_pkg::plq_req_s req = '0;
   plq_pkg::plq_evt_s ev = '0;
   plq_pkg::plq_sym_s sym = '0;
   logic [7:0] tr = 8'h00, rl = 8'h00, ll = 8'h00, txd;
   logic pa = 1'b0, pb = 1'b0, cm = 1'b0, txb = 1'b0, rxb = 1'b0;
   logic fp, sp, wd, txs, rxs;
   logic [8:0] mi = 9'h000, mo;
   logic [15:0] rdata;
   int bad_count = 0;
   int compares = 0;
   plq_regs #(.WIN_CYCLES(16)) dut (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req), .rdata_out(rdata),
      .evt_in(ev), .train_ms_in(tr), .remote_lock_ms_in(rl), .local_lock_ms_in(ll), .sym_in(sym),
      .pattern_a_in(pa), .pattern_b_in(pb), .constant_mode_in(cm), .tx_data_out(txd), .first_pattern_out(fp),
      .second_pattern_out(sp), .watchdog_status_out(wd), .mem_data_in(mi), .mem_data_out(mo),
      .tx_data_bit_in(txb), .rx_data_bit_in(rxb), .tx_scr_bit_out(txs), .rx_descr_bit_out(rxs));
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [15:0] d);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
      @(posedge clk_in);
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      op(1'b1, 1'b0, a, d);
      op(1'b0, 1'b0, a, 16'h0000);
   endtask
   // Read data stands for one cycle only, so it is taken at the falling edge inside that cycle.
   task automatic rc(input logic [11:0] a, input logic [15:0] exp);
      op(1'b0, 1'b1, a, 16'h0000);
      req <= '0;
      @(negedge clk_in);
      chk(rdata, exp);
      @(posedge clk_in);
   endtask
   task automatic wrc(input logic [11:0] a, input logic [15:0] d, input logic [15:0] exp);
      op(1'b1, 1'b0, a, d);
      rc(a, exp);
   endtask
   task automatic t_reset;
      rc(plq_pkg::OFF_TEST, 16'h0000);
      rc(plq_pkg::OFF_TRAIN, 16'h0000);
      rc(plq_pkg::OFF_LOCK, 16'h0000);
      rc(plq_pkg::OFF_LATCH, 16'h0000);
      rc(plq_pkg::OFF_DROP, 16'h0000);
      rc(plq_pkg::OFF_READY, 16'h0000);
      rc(plq_pkg::OFF_WDOG, 16'h0051);
      rc(plq_pkg::OFF_SCR, 16'h0000);
      rc(12'h546, 16'h0000);
      chk({15'h0000, wd}, 16'h0001);
   endtask
   task automatic t_test;
      cm <= 1'b1;
      pa <= 1'b1;
      wrc(plq_pkg::OFF_TEST, 16'hffab, 16'h01ab);
      chk({8'h00, txd}, 16'h00ab);
      chk({14'h0000, fp, sp}, 16'h0001);
      wrc(plq_pkg::OFF_TEST, 16'h00ab, 16'h00ab);
      chk({14'h0000, fp, sp}, 16'h0002);
      cm <= 1'b0;
      cyc(2);
      chk({8'h00, txd}, 16'h0000);
   endtask
   task automatic t_ro;
      tr <= 8'h5a;
      rl <= 8'h3c;
      ll <= 8'hc3;
      cyc(2);
      wrc(plq_pkg::OFF_TRAIN, 16'hffff, 16'h005a);
      wrc(plq_pkg::OFF_LOCK, 16'h0000, 16'h3cc3);
   endtask
   task automatic t_latch;
      ev.fail_inhibit <= 1'b1;
      ev.startup_detect <= 1'b1;
      ev.frame_error_high <= 1'b1;
      cyc(8);
      ev <= '0;
      cyc(8);
      rc(plq_pkg::OFF_LATCH, 16'h001c);
      ev.channel_good <= 1'b1;
      ev.alignment_lock <= 1'b1;
      cyc(8);
      rc(plq_pkg::OFF_LATCH, 16'h003c);
      ev.channel_good <= 1'b0;
      cyc(8);
      rc(plq_pkg::OFF_LATCH, 16'h001c);
      wrc(plq_pkg::OFF_LATCH, 16'h0000, 16'h0003);
      ev.alignment_lock <= 1'b0;
      cyc(8);
      rc(plq_pkg::OFF_LATCH, 16'h0001);
   endtask
   task automatic pulse(input logic loss);
      if (loss) begin
         ev.link_loss <= 1'b1;
      end else begin
         ev.link_fail <= 1'b1;
      end
      cyc(6);
      ev <= '0;
      cyc(6);
   endtask
   // Seventy losses drive the six-bit count to its top of 63, where it holds; a fail during a loss must not count.
   task automatic t_count;
      for (int i = 0; i < 70; i++) pulse(1'b1);
      pulse(1'b0);
      pulse(1'b0);
      ev.link_loss <= 1'b1;
      cyc(6);
      ev.link_fail <= 1'b1;
      cyc(6);
      ev <= '0;
      cyc(8);
      rc(plq_pkg::OFF_DROP, 16'hfc02);
      ev.comm_ready <= 1'b1;
      cyc(8);
      rc(plq_pkg::OFF_READY, 16'h0001);
   endtask
   task automatic t_wdog;
      ev <= '0;
      wr(plq_pkg::OFF_WDOG, 16'h0021);
      cyc(2);
      chk({15'h0000, wd}, 16'h0000);
      wrc(plq_pkg::OFF_WDOG, 16'hff61, 16'h0061);
      chk({15'h0000, wd}, 16'h0001);
      wr(plq_pkg::OFF_WDOG, 16'h0051);
      ev.link_up <= 1'b1;
      cyc(60);
      chk({15'h0000, wd}, 16'h0000);
      sym <= '1;
      cyc(60);
      chk({15'h0000, wd}, 16'h0001);
      sym <= '0;
      rc(plq_pkg::OFF_LATCH, 16'h0000);
   endtask
   task automatic t_scr;
      wrc(plq_pkg::OFF_SCR, 16'hffff, 16'h7fff);
      wr(plq_pkg::OFF_SCR, 16'h6960);
      mi <= 9'h0f0;
      cyc(2);
      chk({7'h00, mo}, 16'h0155);
      wr(plq_pkg::OFF_SCR, 16'h0001);
      txb <= 1'b1;
      cyc(2);
      chk({14'h0000, txs, rxs}, 16'h0002);
      chk({7'h00, mo}, 16'h00f0);
      txb <= 1'b0;
      rxb <= 1'b1;
      cyc(2);
      chk({14'h0000, txs, rxs}, 16'h0001);
   endtask
   // Both scramblers share seed and clock, so with zero data one stream must trail the other by a fixed lag.
   task automatic t_lag(input logic [15:0] cfg, input logic tx_late, input int lag);
      logic [15:0] hist;
      hist = '0;
      wr(plq_pkg::OFF_SCR, cfg);
      txb <= 1'b0;
      rxb <= 1'b0;
      cyc(3);
      repeat (lag) begin
         @(negedge clk_in);
         hist = {hist[14:0], tx_late ? rxs : txs};
      end
      repeat (20) begin
         @(negedge clk_in);
         chk({15'h0000, tx_late ? txs : rxs}, {15'h0000, hist[lag-1]});
         hist = {hist[14:0], tx_late ? rxs : txs};
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      end_of_test;
   end
   initial begin
      cyc(20);
      resetn_in <= 1'b1;
      t_reset;
      t_test;
      t_ro;
      t_latch;
      t_count;
      t_wdog;
      t_scr;
      t_lag(16'h0008, 1'b1, 1);
      t_lag(16'h0010, 1'b0, 1);
      t_lag(16'h0002, 1'b0, 14);
      t_lag(16'h0004, 1'b1, 14);
      end_of_test;
   end
endmodule
`default_nettype wire
